// *** verilog/thit_map.vh ***
`ifndef THIT_MAP_VH
`define THIT_MAP_VH

// partitioning modes
`define THIT_MODE_ONE    2'h0
`define THIT_MODE_TWO    2'h1
`define THIT_MODE_GEN    2'h2

// frames per 24-frame cycle budget
`define THIT_CYCLE_FRAMES 8'h18

// 1:1 offsets and interlace count
`define THIT_O11_FACK    16'h0001
`define THIT_O11_RACK    16'h0002
`define THIT_O11_RASG    16'h0001
`define THIT_O11_ILV     16'h0003
`define THIT_O11_CNT     8'h03

// 2:1 offsets and interlace counts
`define THIT_O21_FACK    16'h0001
`define THIT_O21_RACK    16'h0004
`define THIT_O21_FILV    16'h0005
`define THIT_O21_RILV    16'h0002
`define THIT_O21_FCNT    8'h05
`define THIT_O21_RCNT    8'h02

// generalized offsets in bursts
`define THIT_G_FACK      16'h0001
`define THIT_G_RACK      16'h0002
`define THIT_G_RTX_LONG  16'h0002
`define THIT_G_RTX_SHORT 16'h0003
`define THIT_G_MUL_LONG  8'h02
`define THIT_G_MUL_SHORT 8'h03

// reset values
`define THIT_RST_FRAME   16'h0000
`define THIT_RST_SUPER   16'h0000

`endif

// *** verilog/thit_timing.v ***
`timescale 1ns/1ps
`default_nettype none
`include "thit_map.vh"

// Behaviour
// (R01) 1:1 forward ack k+1, retx k+3n
// (R02) 1:1 reverse asg k+1, ack k+2
// (R03) 2:1 sequence two forward, one reverse
// (R04) superframe index increments each superframe
// (R05) absolute index j times count plus i
// (R06) 2:1 five forward, two reverse interlaces
// (R07) 2:1 forward ack floor(k/2)+1, retx k+5n
// (R08) 2:1 reverse asg floor(k/2), ack 2j+4
// (R09) 2:1 assignments only in even frames
// (R10) general bursts alternate, burst i frame span
// (R11) reverse burst assigned in j or j-1
// (R12) short forward burst needs interlace-selection bits
// (R13) forward ack burst i+1, reverse j+2
// (R14) forward retx burst i+2 or i+3
// (R15) reverse retx burst j+2 or j+3
// (R16) retransmission keeps frame position in burst
// (R17) interlace counts twice or thrice burst length
// (R18) burst lengths two bits, one to four
// (R19) recompute timing each frame from mode
module thit_timing #(
    parameter IW = 16
) (
    input  wire          clk,
    input  wire          resetn,
    input  wire [1:0]    mode,
    input  wire [1:0]    forward_burst_code,
    input  wire [1:0]    reverse_burst_code,
    input  wire          frame_tick,
    output reg  [IW-1:0] superframe_index,
    output reg  [IW-1:0] forward_frame_index,
    output reg  [IW-1:0] reverse_frame_index,
    output reg           forward_link_active,
    output reg           guard_insert,
    output reg           assign_allowed,
    output reg           assign_sel_bits,
    output reg  [IW-1:0] forward_ack_frame,
    output reg  [IW-1:0] forward_retx_frame,
    output reg  [IW-1:0] reverse_assign_frame,
    output reg  [IW-1:0] reverse_ack_frame,
    output reg  [IW-1:0] reverse_retx_frame,
    output reg  [7:0]    forward_interlace,
    output reg  [7:0]    reverse_interlace,
    output reg  [7:0]    forward_interlace_count,
    output reg  [7:0]    reverse_interlace_count
);

    // burst lengths 1..4 from two-bit codes, code 0 meaning one frame
    wire [7:0] forward_burst_length = {6'h00, forward_burst_code} + 8'h01; // [R18]
    wire [7:0] reverse_burst_length = {6'h00, reverse_burst_code} + 8'h01; // [R18]
    wire [7:0] fl_len = (mode == `THIT_MODE_ONE) ? 8'h01 :
                        (mode == `THIT_MODE_TWO) ? 8'h02 : forward_burst_length; // [R03]
    wire [7:0] rl_len = (mode == `THIT_MODE_GEN) ? reverse_burst_length : 8'h01;
    wire [7:0] period = fl_len + rl_len;
    wire [7:0] bursts_per_sf = `THIT_CYCLE_FRAMES / period;
    wire [7:0] forward_frames_per_superframe = fl_len * bursts_per_sf;
    wire [7:0] reverse_frames_per_superframe = rl_len * bursts_per_sf;

    // next superframe number, also the multiplier of the restarted indices
    wire [IW-1:0] next_super = superframe_index + 16'h0001;

    // slot position: frame within the burst, link in use, and frames since superframe start on both links
    reg  [7:0] pos_in_burst;
    reg        in_forward;
    reg  [7:0] sf_fwd;
    reg  [7:0] sf_rev;

    // sequencing advances per frame; guard_insert flags the first reverse frame after each forward burst
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // a run always opens on a forward slot
            pos_in_burst        <= 8'h00;
            in_forward          <= 1'b1;
            sf_fwd              <= 8'h00;
            sf_rev              <= 8'h00;
            superframe_index    <= `THIT_RST_SUPER;
            forward_frame_index <= `THIT_RST_FRAME;
            reverse_frame_index <= `THIT_RST_FRAME;
            forward_link_active <= 1'b1;
            guard_insert        <= 1'b0;
        end
        else if (frame_tick)
        begin
            guard_insert <= 1'b0;
            if (in_forward)
            begin
                // one forward frame elapsed
                forward_frame_index <= forward_frame_index + 16'h0001; // [R05]
                sf_fwd <= sf_fwd + 8'h01;
                if (pos_in_burst + 8'h01 >= fl_len)
                begin
                    in_forward          <= 1'b0; // [R10]
                    forward_link_active <= 1'b0;
                    guard_insert        <= 1'b1; // [R03]
                    pos_in_burst        <= 8'h00;
                end
                else
                    pos_in_burst <= pos_in_burst + 8'h01;
            end
            else
            begin
                // one reverse frame elapsed
                reverse_frame_index <= reverse_frame_index + 16'h0001; // [R05]
                if (pos_in_burst + 8'h01 >= rl_len)
                begin
                    in_forward          <= 1'b1; // [R10]
                    forward_link_active <= 1'b1;
                    pos_in_burst        <= 8'h00;
                    if (sf_rev + 8'h01 >= reverse_frames_per_superframe)
                    begin
                        // superframe boundary; index counts stay j*N+i by construction
                        superframe_index <= next_super; // [R04]
                        sf_fwd <= 8'h00;
                        sf_rev <= 8'h00;
                        forward_frame_index <= next_super
                                               * {8'h00, forward_frames_per_superframe}; // [R05]
                        reverse_frame_index <= next_super
                                               * {8'h00, reverse_frames_per_superframe}; // [R05]
                    end
                    else
                        sf_rev <= sf_rev + 8'h01;
                end
                else
                begin
                    pos_in_burst <= pos_in_burst + 8'h01;
                    sf_rev       <= sf_rev + 8'h01;
                end
            end
        end
    end

    // combinational timing for the current forward frame k and reverse frame
    reg [IW-1:0] next_fack;
    reg [IW-1:0] next_fretx;
    reg [IW-1:0] next_rasg;
    reg [IW-1:0] next_rack;
    reg [IW-1:0] next_rretx;
    reg [7:0]    next_fcnt;
    reg [7:0]    next_rcnt;
    reg          next_allow;
    reg          next_sel;
    reg [IW-1:0] k;
    reg [IW-1:0] j;
    reg [IW-1:0] fb;
    reg [IW-1:0] rb;
    reg [IW-1:0] fpos;
    reg [IW-1:0] rpos;
    reg [IW-1:0] fl16;
    reg [IW-1:0] rl16;

    always @*
    begin
        k    = forward_frame_index;
        j    = reverse_frame_index;
        fl16 = {8'h00, fl_len};
        rl16 = {8'h00, rl_len};
        fb   = k / fl16;
        rb   = j / rl16;
        fpos = k % fl16;
        rpos = j % rl16;
        // only the invalid mode refuses assignments outright
        next_allow = 1'b1;
        next_sel   = 1'b0;
        case (mode)
            // 1:1, three interlaces per link
            `THIT_MODE_ONE:
            begin
                next_fack  = k + `THIT_O11_FACK;            // [R01]
                next_fretx = k + `THIT_O11_ILV;             // [R01]
                next_rasg  = k + `THIT_O11_RASG;            // [R02]
                next_rack  = j + `THIT_O11_RACK;            // [R02]
                next_rretx = j + `THIT_O11_ILV;             // [R02]
                next_fcnt  = `THIT_O11_CNT;                 // [R01]
                next_rcnt  = `THIT_O11_CNT;                 // [R02]
            end
            // 2:1 has its own tuned formulas, not the general ones
            `THIT_MODE_TWO:
            begin
                next_fack  = (k >> 1) + `THIT_O21_FACK;     // [R07]
                next_fretx = k + `THIT_O21_FILV;            // [R07]
                next_rasg  = k >> 1;                        // [R08]
                next_rack  = (j << 1) + `THIT_O21_RACK;     // [R08]
                next_rretx = j + `THIT_O21_RILV;            // [R08]
                next_fcnt  = `THIT_O21_FCNT;                // [R06]
                next_rcnt  = `THIT_O21_RCNT;                // [R06]
                // odd forward frames carry no assignment
                next_allow = ~k[0];                         // [R09]
            end
            `THIT_MODE_GEN:
            begin
                // acks land in the named burst, first frame position
                next_fack = (fb + `THIT_G_FACK) * rl16;    // [R13]
                next_rack = (rb + `THIT_G_RACK) * fl16;    // [R13]
                // retransmissions keep their position within a later burst
                if (rl_len > 8'h01)
                begin
                    next_fretx = (fb + `THIT_G_RTX_LONG) * fl16 + fpos;  // [R14] [R16]
                    next_fcnt  = fl_len * `THIT_G_MUL_LONG;              // [R17]
                end
                else
                begin
                    next_fretx = (fb + `THIT_G_RTX_SHORT) * fl16 + fpos; // [R14] [R16]
                    next_fcnt  = fl_len * `THIT_G_MUL_SHORT;             // [R17]
                end
                // a multi-frame forward burst assigns the following reverse burst
                if (fl_len > 8'h01)
                begin
                    next_rretx = (rb + `THIT_G_RTX_LONG) * rl16 + rpos;  // [R15] [R16]
                    next_rcnt  = rl_len * `THIT_G_MUL_LONG;              // [R17]
                    next_rasg  = fb * rl16;                              // [R11]
                end
                else
                begin
                    next_rretx = (rb + `THIT_G_RTX_SHORT) * rl16 + rpos; // [R15] [R16]
                    next_rcnt  = rl_len * `THIT_G_MUL_SHORT;             // [R17]
                    next_rasg  = (fb + 16'h0001) * rl16;                 // [R11]
                end
                // position carried over only while it fits the reverse burst
                if (fpos < rl16)
                begin
                    next_rasg = next_rasg + fpos;                        // [R12]
                end
                next_sel  = (fl_len < rl_len);              // [R12]
            end
            // invalid code: outputs hold the indices, counts read zero
            default:
            begin
                next_fack  = k;
                next_fretx = k;
                next_rasg  = k;
                next_rack  = j;
                next_rretx = j;
                next_fcnt  = 8'h00;
                next_rcnt  = 8'h00;
                next_allow = 1'b0;
            end
        endcase
    end

    // interlace membership; a zero count only comes from the invalid mode
    reg [IW-1:0] next_fil;
    reg [IW-1:0] next_ril;

    always @*
    begin
        if (next_fcnt == 8'h00)
        begin
            next_fil = {IW{1'b0}};
        end
        else
        begin
            next_fil = k % {8'h00, next_fcnt};
        end
        if (next_rcnt == 8'h00)
        begin
            next_ril = {IW{1'b0}};
        end
        else
        begin
            next_ril = j % {8'h00, next_rcnt};
        end
    end

    // registered results, refreshed every clock so they track each frame change
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            forward_ack_frame       <= `THIT_RST_FRAME;
            forward_retx_frame      <= `THIT_RST_FRAME;
            reverse_assign_frame    <= `THIT_RST_FRAME;
            reverse_ack_frame       <= `THIT_RST_FRAME;
            reverse_retx_frame      <= `THIT_RST_FRAME;
            forward_interlace       <= 8'h00;
            reverse_interlace       <= 8'h00;
            forward_interlace_count <= 8'h00;
            reverse_interlace_count <= 8'h00;
            assign_allowed          <= 1'b0;
            assign_sel_bits         <= 1'b0;
        end
        else
        begin
            forward_ack_frame       <= next_fack;  // [R19]
            forward_retx_frame      <= next_fretx; // [R19]
            reverse_assign_frame    <= next_rasg;
            reverse_ack_frame       <= next_rack;
            reverse_retx_frame      <= next_rretx;
            // remainder is below the 8-bit count, so the low byte holds it all
            forward_interlace       <= next_fil[7:0]; // [R19]
            reverse_interlace       <= next_ril[7:0];
            forward_interlace_count <= next_fcnt;
            reverse_interlace_count <= next_rcnt;
            assign_allowed          <= next_allow & in_forward;
            assign_sel_bits         <= next_sel;
        end
    end

endmodule
`default_nettype wire

// *** tb/thit_frame_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module thit_frame_src (
    input  wire logic clk,
    output var  logic frame_tick
);
    initial frame_tick = 1'b0;
    // one frame end, then idle cycles so the slow case is seen too
    task send(input int idle);
        @(posedge clk);
        frame_tick <= 1'b1;
        @(posedge clk);
        frame_tick <= 1'b0;
        repeat (idle) @(posedge clk);
    endtask
    // back-to-back frame ends, the fastest spacing allowed
    task burst(input int n);
        @(posedge clk);
        frame_tick <= 1'b1;
        repeat (n) @(posedge clk);
        frame_tick <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/thit_timing_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module thit_timing_chk #(
    parameter IW = 16
) (
    input wire logic          clk, resetn, frame_tick, forward_link_active, guard_insert,
    input wire logic          assign_allowed, assign_sel_bits,
    input wire logic [1:0]    mode, forward_burst_code, reverse_burst_code,
    input wire logic [IW-1:0] superframe_index, forward_frame_index, reverse_frame_index,
    input wire logic [IW-1:0] forward_ack_frame, reverse_ack_frame,
    input wire logic [7:0]    forward_interlace_count, reverse_interlace_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // derived outputs land one edge after the index they follow
    a_fwd_ack_one: assert property (frame_tick && mode == 2'h0 |=> ##1
        forward_ack_frame == $past(forward_frame_index) + 1'b1) else $error("fwd ack one");
    a_rev_ack_one: assert property (frame_tick && mode == 2'h0 |=> ##1
        reverse_ack_frame == $past(reverse_frame_index) + 2'h2) else $error("rev ack one");
    a_fwd_ack_two: assert property (frame_tick && mode == 2'h1 |=> ##1
        forward_ack_frame == ($past(forward_frame_index) >> 1) + 1'b1) else $error("fwd ack two");
    a_rev_ack_two: assert property (frame_tick && mode == 2'h1 |=> ##1
        reverse_ack_frame == ($past(reverse_frame_index) << 1) + 3'h4) else $error("rev ack two");
    // index is steady when no tick came last edge, so parity is comparable
    a_even_assign: assert property (mode == 2'h1 && assign_allowed && !$past(frame_tick)
        |-> !forward_frame_index[0]) else $error("odd frame assign");
    a_count_two: assert property (mode == 2'h1 [*3]
        |-> forward_interlace_count == 8'h05 && reverse_interlace_count == 8'h02) else $error("count two");
    a_count_one: assert property (mode == 2'h0 [*3]
        |-> forward_interlace_count == 8'h03 && reverse_interlace_count == 8'h03) else $error("count one");
    a_sel_bits_gen: assert property (mode == 2'h2 [*3]
        |-> assign_sel_bits == (forward_burst_code < reverse_burst_code)) else $error("sel bits");
    a_super_step: assert property (superframe_index != $past(superframe_index)
        |-> superframe_index == $past(superframe_index) + 1'b1) else $error("superframe step");
    a_guard_rev: assert property (guard_insert |-> !forward_link_active) else $error("guard");
    c_two_assign: cover property (mode == 2'h1 && assign_allowed);
    c_gen_sel: cover property (mode == 2'h2 && assign_sel_bits);
    c_new_super: cover property (superframe_index != $past(superframe_index));
endmodule
bind thit_timing thit_timing_chk #(.IW(IW)) i_chk (
    .clk(clk), .resetn(resetn), .frame_tick(frame_tick), .forward_link_active(forward_link_active),
    .guard_insert(guard_insert), .assign_allowed(assign_allowed), .assign_sel_bits(assign_sel_bits),
    .mode(mode), .forward_burst_code(forward_burst_code), .reverse_burst_code(reverse_burst_code),
    .superframe_index(superframe_index), .forward_frame_index(forward_frame_index),
    .reverse_frame_index(reverse_frame_index), .forward_ack_frame(forward_ack_frame),
    .reverse_ack_frame(reverse_ack_frame), .forward_interlace_count(forward_interlace_count),
    .reverse_interlace_count(reverse_interlace_count)
);
`default_nettype wire

// *** tb/tb_tdd_harq_interlace_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "thit_map.vh"
module tb_tdd_harq_interlace_timing;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic [1:0]       mode = 2'h0;
    logic [1:0]       forward_burst_code = 2'h0;
    logic [1:0]       reverse_burst_code = 2'h0;
    wire logic        frame_tick, forward_link_active, guard_insert, assign_allowed, assign_sel_bits;
    wire logic [15:0] superframe_index, forward_frame_index, reverse_frame_index, forward_ack_frame;
    wire logic [15:0] forward_retx_frame, reverse_assign_frame, reverse_ack_frame, reverse_retx_frame;
    wire logic [7:0]  forward_interlace, reverse_interlace, forward_interlace_count, reverse_interlace_count;
    int               errors = 0;
    int               comparisons = 0;
    int               fl, rl, slot;
    always #50 clk = ~clk;
    thit_frame_src i_src (.clk(clk), .frame_tick(frame_tick));
    thit_timing #(.IW(16)) i_dut (
        .clk(clk), .resetn(resetn), .mode(mode), .forward_burst_code(forward_burst_code),
        .reverse_burst_code(reverse_burst_code), .frame_tick(frame_tick), .superframe_index(superframe_index),
        .forward_frame_index(forward_frame_index), .reverse_frame_index(reverse_frame_index),
        .forward_link_active(forward_link_active), .guard_insert(guard_insert), .assign_allowed(assign_allowed),
        .assign_sel_bits(assign_sel_bits), .forward_ack_frame(forward_ack_frame),
        .forward_retx_frame(forward_retx_frame), .reverse_assign_frame(reverse_assign_frame),
        .reverse_ack_frame(reverse_ack_frame), .reverse_retx_frame(reverse_retx_frame),
        .forward_interlace(forward_interlace), .reverse_interlace(reverse_interlace),
        .forward_interlace_count(forward_interlace_count), .reverse_interlace_count(reverse_interlace_count)
    );
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // expectations rebuilt from the indices the block shows right now
    task check_slot;
        int k, j, ph, fm, rm;
        k = forward_frame_index;
        j = reverse_frame_index;
        ph = slot % (fl + rl);
        fm = (rl > 1) ? 2 : 3;
        rm = (fl > 1) ? 2 : 3;
        check(forward_link_active, ph < fl);
        check(guard_insert, ph == fl);
        check(assign_allowed, ph < fl && (mode != `THIT_MODE_TWO || k % 2 == 0));
        if (mode != `THIT_MODE_GEN) check(assign_sel_bits, 0);
        if (mode == `THIT_MODE_ONE)
        begin
            check(forward_ack_frame, k + 1);
            check(forward_retx_frame, k + 3);
            check(forward_interlace, k % 3);
            check(reverse_assign_frame, k + 1);
            check(reverse_ack_frame, j + 2);
            check(reverse_retx_frame, j + 3);
            check(reverse_interlace, j % 3);
            check(forward_interlace_count, 3);
            check(reverse_interlace_count, 3);
        end
        else if (mode == `THIT_MODE_TWO)
        begin
            check(forward_ack_frame, k / 2 + 1);
            check(forward_retx_frame, k + 5);
            check(reverse_assign_frame, k / 2);
            check(reverse_ack_frame, 2 * j + 4);
            check(reverse_retx_frame, j + 2);
            check(forward_interlace, k % 5);
            check(reverse_interlace, j % 2);
            check(forward_interlace_count, 5);
            check(reverse_interlace_count, 2);
        end
        else
        begin
            check(forward_ack_frame, (k / fl + 1) * rl);
            check(forward_retx_frame, k + fm * fl);
            check(reverse_assign_frame, (k / fl + (fl > 1 ? 0 : 1)) * rl + (k % fl < rl ? k % fl : 0));
            check(reverse_ack_frame, (j / rl + 2) * fl);
            check(reverse_retx_frame, j + rm * rl);
            check(forward_interlace_count, fm * fl);
            check(reverse_interlace_count, rm * rl);
            check(forward_interlace, k % (fm * fl));
            check(reverse_interlace, j % (rm * rl));
            check(assign_sel_bits, fl < rl);
        end
    endtask
    task tick(input int idle);
        i_src.send(idle);
        @(posedge clk);
        @(negedge clk);
        slot++;
        check_slot;
    endtask
    // codes change only under reset, so every partitioning starts a fresh superframe
    task start(input logic [1:0] m, input int f, input int r);
        @(posedge clk);
        resetn <= 1'b0;
        mode <= m;
        forward_burst_code <= 2'(f - 1);
        reverse_burst_code <= 2'(r - 1);
        fl = f;
        rl = r;
        slot = 0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_slot;
        repeat (6) tick(slot % 3);
    endtask
    task finish_superframe;
        int n;
        n = 24 / (fl + rl);
        i_src.burst(24 - slot);
        repeat (2) @(posedge clk);
        @(negedge clk);
        slot = 24;
        check(superframe_index, 1);
        check(forward_frame_index, fl * n);
        check(reverse_frame_index, rl * n);
        check_slot;
    endtask
    task run_one_one;
        start(`THIT_MODE_ONE, 1, 1);
        finish_superframe;
    endtask
    task run_two_one;
        start(`THIT_MODE_TWO, 2, 1);
        finish_superframe;
    endtask
    // short, equal and long forward bursts
    task run_general;
        for (int c = 0; c < 3; c++)
        begin
            start(`THIT_MODE_GEN, c + 1, 3 - c);
            finish_superframe;
        end
    endtask
    initial
    begin
        run_one_one;
        run_two_one;
        run_general;
        end_of_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
